// ==== rtl/diag_alarm_defines.vh ====
// Offsets, field positions, reset values and sample constants of the diagnostic and alarm block
`ifndef DIAG_ALARM_DEFINES_VH
`define DIAG_ALARM_DEFINES_VH

// Byte addresses of the low byte of each 16-bit register; the high byte sits at +1
`define ADDR_ALARM_ONE_THRESHOLD    7'h26
`define ADDR_ALARM_TWO_THRESHOLD    7'h28
`define ADDR_ALARM_ONE_SAMPLE_COUNT 7'h2A
`define ADDR_ALARM_TWO_SAMPLE_COUNT 7'h2C
`define ADDR_ALARM_CONTROL          7'h2E
`define ADDR_DIAGNOSTIC_FLAGS       7'h3C

`define REG_RESET_VALUE             16'h0000

// Alarm control fields
`define CTRL_SRC_TWO_HI             15
`define CTRL_SRC_TWO_LO             12
`define CTRL_SRC_ONE_HI             11
`define CTRL_SRC_ONE_LO             8
`define CTRL_RATE_TWO               7
`define CTRL_RATE_ONE               6
`define CTRL_FILTERED               4
`define CTRL_OUT_ENABLE             2
`define CTRL_OUT_POLARITY           1
`define CTRL_OUT_LINE               0

// Threshold fields
`define THR_DIRECTION               15
`define THR_LEVEL_HI                13

// Diagnostic flag fields
`define DIAG_ACCEL_ST_HI            15
`define DIAG_GYRO_ST_LO             10
`define DIAG_ALARM_TWO              9
`define DIAG_ALARM_ONE              8
`define DIAG_FLASH_CHECKSUM         6
`define DIAG_ST_DIAG_ERR            5
`define DIAG_OVERRANGE              4
`define DIAG_COMM_FAIL              3
`define DIAG_FLASH_UPDATE           2
`define DIAG_SUPPLY_HIGH            1
`define DIAG_SUPPLY_LOW             0

// Source selection
`define SRC_DISABLE                 4'h0
`define SRC_LAST                    4'hB
`define SRC_COUNT                   12
`define DATA_WIDTH                  14

// Sample window
`define SAMPLE_COUNT_MIN            8'h01

`endif

// ==== rtl/alarm_channel.v ====
// One alarm channel: static level or rate-of-change comparison against a threshold
`timescale 1ns/100ps
`default_nettype none
`include "diag_alarm_defines.vh"

module alarm_channel (
  input  wire        core_clk_in,    // Core clock
  input  wire        rst_n_in,       // Asynchronous reset, active low
  input  wire        sample_tick_in, // One pulse per internal sample
  input  wire        enable_in,      // Source select is not disable
  input  wire        rate_in,        // 1 = rate of change, 0 = static
  input  wire        greater_in,     // 1 = greater than, 0 = less than
  input  wire [13:0] level_in,       // Threshold level
  input  wire [7:0]  count_in,       // Samples in the rate window
  input  wire [13:0] value_in,       // Selected source value
  output reg         active_out      // Alarm condition, updated per sample in static mode, once per sample window in rate mode
);

  reg  [7:0]  win_cnt_r;
  reg  [13:0] ref_r;
  reg         primed_r;
  wire [7:0]  eff_count;
  wire [14:0] delta;

  // Signed compare of a 15-bit quantity against the sign-extended level
  function cmp;
    input [14:0] x;
    input [13:0] thr;
    input        gt;
    begin
      if (gt) begin
        cmp = $signed(x) > $signed({thr[13], thr});
      end else begin
        cmp = $signed(x) < $signed({thr[13], thr});
      end
    end
  endfunction

  assign eff_count = (count_in < `SAMPLE_COUNT_MIN) ? `SAMPLE_COUNT_MIN : count_in;
  assign delta     = {value_in[13], value_in} - {ref_r[13], ref_r};

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_cnt_r  <= 8'h00;
      ref_r      <= 14'h0000;
      primed_r   <= 1'b0;
      active_out <= 1'b0;
    end else if (!enable_in || (!rate_in && primed_r)) begin
      win_cnt_r  <= 8'h00;
      primed_r   <= 1'b0;
      active_out <= enable_in ? active_out : 1'b0;
    end else if (sample_tick_in) begin
      if (!rate_in) begin
        active_out <= cmp({value_in[13], value_in}, level_in, greater_in);
      end else if (!primed_r) begin
        // First sample only takes the reference; there is no older sample yet
        ref_r     <= value_in;
        primed_r  <= 1'b1;
        win_cnt_r <= 8'h00;
      end else if (win_cnt_r + 8'h01 >= eff_count) begin
        active_out <= cmp(delta, level_in, greater_in);
        ref_r      <= value_in;
        win_cnt_r  <= 8'h00;
      end else begin
        win_cnt_r <= win_cnt_r + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/diag_alarm_monitor.v ====
// Diagnostic flag register and two-channel alarm monitor with byte-wide register port
`timescale 1ns/100ps
`default_nettype none
`include "diag_alarm_defines.vh"

module diag_alarm_monitor (
  input  wire         core_clk_in,             // 50 MHz core clock
  input  wire         rst_n_in,                // Asynchronous reset, active low
  input  wire         sample_tick_in,          // One pulse per internal sample
  input  wire [6:0]   reg_addr_in,             // Register byte address
  input  wire         reg_wr_in,               // Byte write strobe
  input  wire [7:0]   reg_wdata_in,            // Byte write data
  input  wire         reg_rd_in,               // Completed word read strobe
  input  wire [167:0] src_unfilt_in,           // Sources 1..11 unfiltered, 14 bits each
  input  wire [167:0] src_filt_in,             // Sources 1..11 filtered, 14 bits each
  input  wire [5:0]   st_fail_in,              // Self-test fail: az ay ax gz gy gx
  input  wire         flash_checksum_fail_in,  // Flash checksum fault
  input  wire         st_diag_err_in,          // Self-test diagnostic error
  input  wire         overrange_in,            // Sensor overrange
  input  wire         comm_fail_in,            // Serial communication failure
  input  wire         flash_update_fail_in,    // Flash update failure
  input  wire         supply_high_in,          // Supply above 5.25 V
  input  wire         supply_low_in,           // Supply below 4.75 V
  output reg  [15:0]  rd_data_out,             // Read data, valid the cycle after read
  output reg          digital_line_one_out,    // Line one output level
  output reg          digital_line_one_oe_out, // Line one output enable
  output reg          digital_line_two_out,    // Line two output level
  output reg          digital_line_two_oe_out  // Line two output enable
);

  reg  [15:0] diagnostic_flags_r;
  reg  [15:0] alarm_one_threshold_r;
  reg  [15:0] alarm_two_threshold_r;
  reg  [15:0] alarm_one_sample_count_r;
  reg  [15:0] alarm_two_sample_count_r;
  reg  [15:0] alarm_control_r;
  reg  [15:0] flag_set;
  reg  [15:0] flags_nxt;
  reg  [15:0] rd_nxt;
  wire        alarm_one_active;
  wire        alarm_two_active;
  wire [3:0]  src_one;
  wire [3:0]  src_two;
  wire [167:0] src_bus;
  wire [13:0] value_one;
  wire [13:0] value_two;
  wire        diag_read;
  wire        any_alarm;
  wire        line_level;
  wire [6:0]  word_addr;
  reg  [15:0] alarm_one_threshold_nxt;
  reg  [15:0] alarm_two_threshold_nxt;
  reg  [15:0] alarm_one_sample_count_nxt;
  reg  [15:0] alarm_two_sample_count_nxt;
  reg  [15:0] alarm_control_nxt;
  reg         line_one_nxt;
  reg         line_one_oe_nxt;
  reg         line_two_nxt;
  reg         line_two_oe_nxt;

  // Picks source 1..11 out of the packed bus; codes above the table read as zero
  function [13:0] pick_source;
    input [167:0] bus;
    input [3:0]   code;
    integer       i;
    begin
      pick_source = 14'h0000;
      for (i = 1; i < `SRC_COUNT; i = i + 1) begin
        if (code == i[3:0]) begin
          pick_source = bus[(i - 1) * `DATA_WIDTH +: `DATA_WIDTH];
        end
      end
    end
  endfunction

  // Byte merge for a 16-bit register written one byte at a time
  function [15:0] merge_byte;
    input [15:0] cur;
    input        hi;
    input [7:0]  data;
    begin
      merge_byte = hi ? {data, cur[7:0]} : {cur[15:8], data};
    end
  endfunction

  assign word_addr = {reg_addr_in[6:1], 1'b0};

  assign src_two = alarm_control_r[`CTRL_SRC_TWO_HI:`CTRL_SRC_TWO_LO];
  assign src_one = alarm_control_r[`CTRL_SRC_ONE_HI:`CTRL_SRC_ONE_LO];
  assign src_bus = alarm_control_r[`CTRL_FILTERED] ? src_filt_in : src_unfilt_in;
  assign value_one = pick_source(src_bus, src_one);
  assign value_two = pick_source(src_bus, src_two);

  alarm_channel u_alarm_one (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .sample_tick_in (sample_tick_in),
    .enable_in      (src_one != `SRC_DISABLE),
    .rate_in        (alarm_control_r[`CTRL_RATE_ONE]),
    .greater_in     (alarm_one_threshold_r[`THR_DIRECTION]),
    .level_in       (alarm_one_threshold_r[`THR_LEVEL_HI:0]),
    .count_in       (alarm_one_sample_count_r[7:0]),
    .value_in       (value_one),
    .active_out     (alarm_one_active)
  );

  alarm_channel u_alarm_two (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .sample_tick_in (sample_tick_in),
    .enable_in      (src_two != `SRC_DISABLE),
    .rate_in        (alarm_control_r[`CTRL_RATE_TWO]),
    .greater_in     (alarm_two_threshold_r[`THR_DIRECTION]),
    .level_in       (alarm_two_threshold_r[`THR_LEVEL_HI:0]),
    .count_in       (alarm_two_sample_count_r[7:0]),
    .value_in       (value_two),
    .active_out     (alarm_two_active)
  );

  assign diag_read = reg_rd_in && (word_addr == `ADDR_DIAGNOSTIC_FLAGS);

  // Fault conditions as seen at this sample; bit 7 never sets
  always @* begin
    flag_set = 16'h0000;
    flag_set[`DIAG_ACCEL_ST_HI:`DIAG_GYRO_ST_LO] = st_fail_in;
    flag_set[`DIAG_ALARM_TWO]      = alarm_two_active;
    flag_set[`DIAG_ALARM_ONE]      = alarm_one_active;
    flag_set[`DIAG_FLASH_CHECKSUM] = flash_checksum_fail_in;
    flag_set[`DIAG_ST_DIAG_ERR]    = st_diag_err_in;
    flag_set[`DIAG_OVERRANGE]      = overrange_in;
    flag_set[`DIAG_COMM_FAIL]      = comm_fail_in;
    flag_set[`DIAG_FLASH_UPDATE]   = flash_update_fail_in;
    flag_set[`DIAG_SUPPLY_HIGH]    = supply_high_in;
    flag_set[`DIAG_SUPPLY_LOW]     = supply_low_in;
  end

  always @* begin
    flags_nxt = diagnostic_flags_r;
    if (diag_read) begin
      flags_nxt = 16'h0000;
    end
    flags_nxt[`DIAG_SUPPLY_HIGH] = flags_nxt[`DIAG_SUPPLY_HIGH] & supply_high_in;
    flags_nxt[`DIAG_SUPPLY_LOW]  = flags_nxt[`DIAG_SUPPLY_LOW] & supply_low_in;
    // set again at sample
    // A sample in the read cycle wins, so no fault is lost to the clear
    if (sample_tick_in) begin
      flags_nxt = flags_nxt | flag_set;
    end
  end

  // Read mux; unmapped addresses read as zero
  always @* begin
    rd_nxt = rd_data_out;
    if (reg_rd_in) begin
      case (word_addr)
        `ADDR_DIAGNOSTIC_FLAGS:       rd_nxt = diagnostic_flags_r;
        `ADDR_ALARM_ONE_THRESHOLD:    rd_nxt = alarm_one_threshold_r;
        `ADDR_ALARM_TWO_THRESHOLD:    rd_nxt = alarm_two_threshold_r;
        `ADDR_ALARM_ONE_SAMPLE_COUNT: rd_nxt = alarm_one_sample_count_r;
        `ADDR_ALARM_TWO_SAMPLE_COUNT: rd_nxt = alarm_two_sample_count_r;
        `ADDR_ALARM_CONTROL:          rd_nxt = alarm_control_r;
        default:                      rd_nxt = 16'h0000;
      endcase
    end
  end

  // Writes land one byte at a time through masks, so unused bits always read back zero
  always @* begin
    alarm_one_threshold_nxt    = alarm_one_threshold_r;
    alarm_two_threshold_nxt    = alarm_two_threshold_r;
    alarm_one_sample_count_nxt = alarm_one_sample_count_r;
    alarm_two_sample_count_nxt = alarm_two_sample_count_r;
    alarm_control_nxt          = alarm_control_r;
    if (reg_wr_in) begin
      case (word_addr)
        `ADDR_ALARM_ONE_THRESHOLD: begin
          alarm_one_threshold_nxt = merge_byte(alarm_one_threshold_r, reg_addr_in[0],
                                               reg_wdata_in) & 16'hBFFF;
        end
        `ADDR_ALARM_TWO_THRESHOLD: begin
          alarm_two_threshold_nxt = merge_byte(alarm_two_threshold_r, reg_addr_in[0],
                                               reg_wdata_in) & 16'hBFFF;
        end
        `ADDR_ALARM_ONE_SAMPLE_COUNT: begin
          alarm_one_sample_count_nxt = merge_byte(alarm_one_sample_count_r, reg_addr_in[0],
                                                  reg_wdata_in) & 16'h00FF;
        end
        `ADDR_ALARM_TWO_SAMPLE_COUNT: begin
          alarm_two_sample_count_nxt = merge_byte(alarm_two_sample_count_r, reg_addr_in[0],
                                                  reg_wdata_in) & 16'h00FF;
        end
        `ADDR_ALARM_CONTROL: begin
          alarm_control_nxt = merge_byte(alarm_control_r, reg_addr_in[0],
                                         reg_wdata_in) & 16'hFFD7;
        end
        // Flag register and unmapped addresses ignore writes
        default: begin
          alarm_control_nxt = alarm_control_r;
        end
      endcase
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      diagnostic_flags_r       <= `REG_RESET_VALUE;
      alarm_one_threshold_r    <= `REG_RESET_VALUE;
      alarm_two_threshold_r    <= `REG_RESET_VALUE;
      alarm_one_sample_count_r <= `REG_RESET_VALUE;
      alarm_two_sample_count_r <= `REG_RESET_VALUE;
      alarm_control_r          <= `REG_RESET_VALUE;
      rd_data_out              <= 16'h0000;
    end else begin
      diagnostic_flags_r       <= flags_nxt;
      alarm_one_threshold_r    <= alarm_one_threshold_nxt;
      alarm_two_threshold_r    <= alarm_two_threshold_nxt;
      alarm_one_sample_count_r <= alarm_one_sample_count_nxt;
      alarm_two_sample_count_r <= alarm_two_sample_count_nxt;
      alarm_control_r          <= alarm_control_nxt;
      rd_data_out              <= rd_nxt;
    end
  end

  assign any_alarm  = alarm_one_active | alarm_two_active;
  assign line_level = alarm_control_r[`CTRL_OUT_POLARITY] ? any_alarm : ~any_alarm;

  // enable and line select
  // Polarity low idles the enabled line high while no alarm is active
  always @* begin
    line_one_nxt    = 1'b0;
    line_one_oe_nxt = 1'b0;
    line_two_nxt    = 1'b0;
    line_two_oe_nxt = 1'b0;
    if (alarm_control_r[`CTRL_OUT_ENABLE]) begin
      if (alarm_control_r[`CTRL_OUT_LINE]) begin
        line_two_oe_nxt = 1'b1;
        line_two_nxt    = line_level;
      end else begin
        line_one_oe_nxt = 1'b1;
        line_one_nxt    = line_level;
      end
    end
  end

  // Lines not enabled stay undriven and low internally so the pin can serve other uses
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      digital_line_one_out    <= 1'b0;
      digital_line_one_oe_out <= 1'b0;
      digital_line_two_out    <= 1'b0;
      digital_line_two_oe_out <= 1'b0;
    end else begin
      digital_line_one_out    <= line_one_nxt;
      digital_line_one_oe_out <= line_one_oe_nxt;
      digital_line_two_out    <= line_two_nxt;
      digital_line_two_oe_out <= line_two_oe_nxt;
    end
  end

  // sample period base comes in as sample_tick_in from the rate logic outside

endmodule
`default_nettype wire

// ==== verif/diag_alarm_checker_monitor.sv ====
// Port-level assertions for the diagnostic flag and alarm monitor
`timescale 1ns/100ps
`default_nettype none
module diag_alarm_checker (
  input wire logic        core_clk_in,             // Clock
  input wire logic        rst_n_in,                // Reset, active low
  input wire logic        sample_tick_in,          // Sample pulse
  input wire logic [6:0]  reg_addr_in,             // Byte address
  input wire logic        reg_wr_in,               // Byte write
  input wire logic [7:0]  reg_wdata_in,            // Write byte
  input wire logic        reg_rd_in,               // Word read
  input wire logic        overrange_in,            // Overrange fault
  input wire logic        supply_high_in,          // Supply high
  input wire logic        supply_low_in,           // Supply low
  input wire logic [15:0] rd_data_out,             // Read data
  input wire logic        digital_line_one_out,    // Line one level
  input wire logic        digital_line_one_oe_out, // Line one enable
  input wire logic        digital_line_two_out,    // Line two level
  input wire logic        digital_line_two_oe_out  // Line two enable
);
  wire         rd_flags = reg_rd_in && reg_addr_in[6:1] == 6'h1E;
  wire         wr_ctrl  = reg_wr_in && reg_addr_in[6:1] == 6'h17;
  logic [15:0] ctrl_r;
  logic [2:0]  age_r;
  logic        ovr_r;
  logic        low_r;

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= 16'h0000;
      age_r  <= 3'h0;
      ovr_r  <= 1'b0;
      low_r  <= 1'b0;
    end else begin
      if (wr_ctrl && reg_addr_in[0]) ctrl_r[15:8] <= reg_wdata_in;
      if (wr_ctrl && !reg_addr_in[0]) ctrl_r[7:0] <= reg_wdata_in;
      age_r <= wr_ctrl ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
      // Sets pending since the last flag read; a set in the read cycle wins
      ovr_r <= (sample_tick_in && overrange_in) || (ovr_r && !rd_flags);
      low_r <= supply_low_in && (sample_tick_in || (low_r && !rd_flags));
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_quiet_read;
    rd_flags && !sample_tick_in;
  endsequence
  sequence s_supply_ok;
    !supply_high_in && !supply_low_in;
  endsequence

  property p_read_clear;
    s_quiet_read ##1 !sample_tick_in ##1 s_quiet_read |=> rd_data_out == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags kept after read");
  property p_reappear;
    rd_flags && ovr_r |=> rd_data_out[4];
  endproperty
  a_reappear: assert property (p_reappear) else $error("overrange flag missing");
  property p_supply_clear;
    s_supply_ok ##1 s_supply_ok ##1 rd_flags |=> rd_data_out[1:0] == 2'b00;
  endproperty
  a_supply_clear: assert property (p_supply_clear) else $error("supply flag stuck");
  property p_supply_low;
    rd_flags && low_r |=> rd_data_out[0];
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("low supply flag missing");
  property p_bit7;
    rd_flags |=> !rd_data_out[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("unused flag bit set");
  property p_line_sel;
    age_r == 3'h7 |-> digital_line_two_oe_out == (ctrl_r[2] && ctrl_r[0])
      && digital_line_one_oe_out == (ctrl_r[2] && !ctrl_r[0]);
  endproperty
  a_line_sel: assert property (p_line_sel) else $error("line enable wrong");
  property p_src_off;
    age_r[2] && ctrl_r[15:8] == 8'h00 && ctrl_r[2]
      |-> (ctrl_r[0] ? digital_line_two_out : digital_line_one_out) == !ctrl_r[1];
  endproperty
  a_src_off: assert property (p_src_off) else $error("disabled alarm drives line");
  property p_reset;
    $rose(rst_n_in) |-> rd_data_out == 16'h0000 && !digital_line_one_oe_out
      && !digital_line_two_oe_out;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind diag_alarm_monitor diag_alarm_checker u_chk (.core_clk_in, .rst_n_in, .sample_tick_in,
  .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .overrange_in, .supply_high_in,
  .supply_low_in, .rd_data_out, .digital_line_one_out, .digital_line_one_oe_out,
  .digital_line_two_out, .digital_line_two_oe_out);
`default_nettype wire

// ==== verif/host_model.sv ====
// Host controller model on the byte-wide register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clk_in,    // Core clock
  output logic      [6:0] addr_out,  // Byte address
  output logic            wr_out,    // Byte write strobe
  output logic      [7:0] wdata_out, // Write byte
  output logic            rd_out     // Word read strobe
);
  initial begin
    addr_out  = 7'h00;
    wr_out    = 1'b0;
    wdata_out = 8'h00;
    rd_out    = 1'b0;
  end

  // Low byte first; each byte takes effect on its own
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wr_out    <= 1'b1;
    wdata_out <= d[7:0];
    @(posedge clk_in);
    addr_out  <= a | 7'h01;
    wdata_out <= d[15:8];
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d[15:8];
  endtask

  task automatic rd(input logic [6:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the diagnostic flag and alarm monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic         core_clk_in, rst_n_in, sample_tick_in, reg_wr_in, reg_rd_in;
  logic [6:0]   reg_addr_in;
  logic [7:0]   reg_wdata_in;
  logic [167:0] src_unfilt_in, src_filt_in;
  logic [5:0]   st_fail_in;
  logic         flash_checksum_fail_in, st_diag_err_in, overrange_in, comm_fail_in;
  logic         flash_update_fail_in, supply_high_in, supply_low_in, rd_seen;
  logic [15:0]  rd_data_out, ctl;
  logic         digital_line_one_out, digital_line_one_oe_out;
  logic         digital_line_two_out, digital_line_two_oe_out;
  logic [15:0]  exp_q[$];
  logic [12:0]  cond;
  logic [31:0]  seed = 32'hEF8A2B89;
  logic [6:0]   adr [7] = '{7'h26, 7'h28, 7'h2A, 7'h2C, 7'h2E, 7'h3C, 7'h40};
  logic [15:0]  msk [7] = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'hFFD7, 16'h0, 16'h0};
  logic [4:0]   rexp [2] = '{5'h0C, 5'h02};
  int           bad_count = 0, check_count = 0, cyc = 0;

  diag_alarm_monitor uut (.core_clk_in, .rst_n_in, .sample_tick_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rd_in, .src_unfilt_in, .src_filt_in, .st_fail_in,
    .flash_checksum_fail_in, .st_diag_err_in, .overrange_in, .comm_fail_in,
    .flash_update_fail_in, .supply_high_in, .supply_low_in, .rd_data_out,
    .digital_line_one_out, .digital_line_one_oe_out, .digital_line_two_out,
    .digital_line_two_oe_out);
  host_model host (.clk_in(core_clk_in), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
    .wdata_out(reg_wdata_in), .rd_out(reg_rd_in));

  assign {st_fail_in, flash_checksum_fail_in, st_diag_err_in, overrange_in, comm_fail_in,
    flash_update_fail_in, supply_high_in, supply_low_in} = cond;

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value read data expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_line(input logic [3:0] e);
    logic [3:0] s;
    s = {digital_line_one_oe_out, digital_line_one_out, digital_line_two_oe_out,
      digital_line_two_out};
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value lines expected %b seen %b", e, s);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // Lines settle two cycles after the sample edge
  task automatic tick();
    @(posedge core_clk_in) sample_tick_in <= 1'b1;
    @(posedge core_clk_in) sample_tick_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    rd_seen <= reg_rd_in;
    if (rd_seen === 1'b1)
      cmp_word(exp_q.pop_front(), rd_data_out);
  end

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    sample_tick_in = 1'b0;
    cond = 13'h0000;
    src_unfilt_in = 168'h0;
    src_filt_in = 168'h0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(adr[i], 16'h0000);
      seed = xs(seed);
      host.wr(adr[i], seed[15:0]);
      rd_chk(adr[i], seed[15:0] & msk[i]);
    end
    host.wr(7'h2E, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge core_clk_in) cond <= seed[12:0];
      tick();
      @(posedge core_clk_in) cond <= seed[12:0] & 13'h1FFC;
      repeat (2) @(posedge core_clk_in);
      rd_chk(7'h3C, {seed[12:7], 3'h0, seed[6:2], 2'h0});
      rd_chk(7'h3C, 16'h0000);
    end
    @(posedge core_clk_in) cond <= 13'h0013;
    tick();
    rd_chk(7'h3C, 16'h0013);
    tick();
    rd_chk(7'h3C, 16'h0013);
    @(posedge core_clk_in) cond <= 13'h0000;
    $display("test flags done");
    host.wr(7'h26, 16'h8005);
    host.wr(7'h28, 16'h0007);
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 1; c < 12; c++) begin
        @(posedge core_clk_in) src_unfilt_in <= 168'h6 << ((c - 1) * 14);
        src_filt_in <= (ch ? 168'h8 : 168'h0) << ((c - 1) * 14);
        ctl = {ch ? {c[3:0], 4'h0} : {4'h0, c[3:0]}, 5'h00, 1'b1, c[0], c[1]};
        host.wr(7'h2E, ctl);
        tick();
        cmp_line(c[1] ? {2'b00, 1'b1, c[0]} : {1'b1, c[0], 2'b00});
        host.wr(7'h2E, ctl | 16'h0010);
        tick();
        cmp_line(c[1] ? {2'b00, 1'b1, !c[0]} : {1'b1, !c[0], 2'b00});
      end
    end
    rd_chk(7'h3C, 16'h0300);
    host.wr(7'h2E, 16'hB007);
    tick();
    cmp_line(4'b0011);
    host.wr(7'h2E, 16'h0007);
    repeat (4) @(posedge core_clk_in);
    cmp_line(4'b0010);
    $display("test static alarms done");
    for (int k = 0; k < 2; k++) begin
      host.wr(7'h2E, 16'h0007);
      @(posedge core_clk_in) src_unfilt_in <= 168'h0;
      host.wr(7'h2A, k ? 16'h0000 : 16'h0002);
      host.wr(7'h2E, 16'h0147);
      for (int t = 0; t < 5; t++) begin
        tick();
        cmp_line({3'b001, rexp[k][t]});
        @(posedge core_clk_in) src_unfilt_in <= 168'hA;
      end
    end
    $display("test rate alarms done");
    repeat (3) @(posedge core_clk_in);
    final_report();
  end
endmodule
`default_nettype wire
